/* chgadc_consts.vh */
// Purpose: constants for the charger monitor result register bank
// Assumes: byte-wide register port behind the serial control interface
// Notes:   definitions only
// Contract
// [RULE1] input current at 31h, signed mA, zero reset
// [RULE2] current toward mid node reads positive
// [RULE3] battery current at 33h, signed mA, zero reset
// [RULE4] discharge negative only when sense enable set
// [RULE5] input bus voltage at 35h, unsigned mV
// [RULE6] adapter one voltage at 37h, mV
// [RULE7] adapter two voltage at 39h, mV
// [RULE8] battery sense voltage at 3Bh, mV
// [RULE9] system voltage at 3Dh, mV
// [RULE10] thermistor ratio at 3Fh, percent steps
// [RULE11] die temperature at 41h, signed half degrees
// [RULE12] word spans two bytes, read in one burst
// [RULE13] result writes ignored; update on conversion only
// [RULE14] convert only while enable set; enable resets
// [RULE15] rate bit zero continuous, one single pass
// [RULE16] per-channel disable bit excludes channel
// [RULE17] running average seeded from old or fresh
`ifndef CHGADC_CONSTS_VH
`define CHGADC_CONSTS_VH

// control register offsets
`define CHGADC_OFS_CHG_CTRL   8'h14
`define CHGADC_OFS_ADC_CTRL   8'h2E
`define CHGADC_OFS_ADC_DIS0   8'h2F
`define CHGADC_OFS_ADC_DIS1   8'h30
// result register offsets, msb byte at offset, lsb at offset+1
`define CHGADC_OFS_IN_CUR     8'h31
`define CHGADC_OFS_BAT_CUR    8'h33
`define CHGADC_OFS_IN_VOLT    8'h35
`define CHGADC_OFS_AD1_VOLT   8'h37
`define CHGADC_OFS_AD2_VOLT   8'h39
`define CHGADC_OFS_BAT_VOLT   8'h3B
`define CHGADC_OFS_SYS_VOLT   8'h3D
`define CHGADC_OFS_THERM      8'h3F
`define CHGADC_OFS_DIE_TEMP   8'h41
`define CHGADC_OFS_LAST       8'h42

// field positions
`define CHGADC_BIT_DSCHG_EN   5
`define CHGADC_BIT_EN         7
`define CHGADC_BIT_RATE       6
`define CHGADC_BIT_AVG        3
`define CHGADC_BIT_AVG_INIT   2

// reset values
`define CHGADC_RST_ADC_CTRL   8'h30
`define CHGADC_RST_DIS        8'h00
`define CHGADC_RST_RESULT     16'h0000

// channel count and codes (order of the result map)
`define CHGADC_NCH            9
`define CHGADC_CH_IBUS        4'h0
`define CHGADC_CH_IBAT        4'h1
`define CHGADC_CH_TDIE        4'h8

`endif

/* chgadc_result_cell.v */
// Purpose: one 16-bit conversion result with optional running average
// Assumes: load pulses only when a conversion of this channel completes
// Notes:   signed cells average arithmetically, unsigned ones logically
`include "chgadc_consts.vh"
module chgadc_result_cell #(
	parameter IS_SIGNED = 0
) (
	input  wire        i_clk,
	input  wire        i_rst_n,
	input  wire        i_load,
	input  wire [15:0] i_sample,
	input  wire        i_avg,
	input  wire        i_avg_init,
	input  wire        i_run_start,
	output reg  [15:0] o_value
);
	reg         seeded;      // average has a starting point
	wire        ext_old;     // sign extension of held value
	wire        ext_new;     // sign extension of new sample
	wire [16:0] sum;         // 17-bit sum avoids overflow
	assign ext_old = (IS_SIGNED != 0) ? o_value[15] : 1'b0;
	assign ext_new = (IS_SIGNED != 0) ? i_sample[15] : 1'b0;
	assign sum     = {ext_old, o_value} + {ext_new, i_sample};

	// result update, only on a completed conversion
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_value <= `CHGADC_RST_RESULT;
			seeded  <= 1'b0;
		end else begin
			if (i_run_start)
				seeded <= 1'b0;
			if (i_load) begin
				seeded <= 1'b1;
				// [RULE17] average seed choice
				if (!i_avg)
					o_value <= i_sample;
				else if (!seeded && i_avg_init)
					o_value <= i_sample;      // fresh conversion seeds
				else
					o_value <= sum[16:1];     // mean of old and new
			end
		end
	end
endmodule // chgadc_result_cell

/* chgadc_results.v */
// Purpose: monitor result bank, its control bits and the channel scan
// Assumes: byte register port decoded by the serial interface; converter
//          outside returns one raw 16-bit code per start request
// Notes:   msb byte first; reading an msb freezes its lsb for the burst
`include "chgadc_consts.vh"
module chgadc_results (
	input  wire        i_mclk,
	input  wire        i_nrst,
	input  wire        i_reg_reset,
	input  wire        i_wdt_expire,
	input  wire [7:0]  i_reg_addr,
	input  wire        i_reg_wr,
	input  wire        i_reg_rd,
	input  wire [7:0]  i_reg_wdata,
	output reg  [7:0]  o_reg_rdata,
	output reg         o_reg_rvalid,
	output reg         o_conv_start,
	output reg  [3:0]  o_conv_chan,
	input  wire        i_conv_done,
	input  wire [15:0] i_conv_data,
	output wire        o_conv_busy
);
	localparam S_IDLE = 2'b00;   // converter off
	localparam S_PICK = 2'b01;   // choose next channel
	localparam S_WAIT = 2'b10;   // waiting for converter

	reg         rst_meta;        // reset release synchroniser
	reg         rst_n;           // synchronised reset
	reg  [7:0]  adc_ctrl;        // enable, rate, sample, averaging
	reg  [7:0]  dis0;            // channel disables, first group
	reg  [7:0]  dis1;            // channel disables, second group
	reg         dschg_en;        // discharge current sense enable
	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [3:0]  chan;            // channel under scan
	reg         en_d;            // enable one cycle ago
	reg  [7:0]  shadow;          // frozen lsb for coherent burst
	reg  [3:0]  shadow_chan;
	reg         shadow_ok;
	reg  [8:0]  ch_off;          // per-channel disable, map order
	reg  [15:0] sample;          // sample after sign policy
	wire [143:0] values;         // all results, channel k at [16k+15:16k]
	wire [7:0]  rel;             // address relative to first result
	wire        res_hit;
	wire [3:0]  res_idx;
	wire [15:0] res_word;
	wire        run_start;
	wire        last_chan;

	assign rel       = i_reg_addr - `CHGADC_OFS_IN_CUR;
	assign res_hit   = (i_reg_addr >= `CHGADC_OFS_IN_CUR) && (i_reg_addr <= `CHGADC_OFS_LAST);
	assign res_idx   = rel[4:1];
	assign res_word  = values[res_idx*16 +: 16];
	assign run_start = adc_ctrl[`CHGADC_BIT_EN] && !en_d;
	assign last_chan = (chan == `CHGADC_CH_TDIE);
	assign o_conv_busy = (state == S_WAIT);

	// reset release through two flops
	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// disable bits gathered in result map order
	always @* begin
		// [RULE16] channel disable map
		ch_off[0] = dis0[7];
		ch_off[1] = dis0[6];
		ch_off[2] = dis0[5];
		ch_off[3] = dis1[4];
		ch_off[4] = dis1[5];
		ch_off[5] = dis0[4];
		ch_off[6] = dis0[3];
		ch_off[7] = dis0[2];
		ch_off[8] = dis0[1];
	end

	// battery current sign policy
	always @* begin
		sample = i_conv_data;
		// [RULE4] discharge shown only when enabled
		if (chan == `CHGADC_CH_IBAT && !dschg_en && i_conv_data[15])
			sample = 16'h0000;
	end

	// control registers; result offsets are not writable
	always @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			adc_ctrl <= `CHGADC_RST_ADC_CTRL;
			dis0     <= `CHGADC_RST_DIS;
			dis1     <= `CHGADC_RST_DIS;
			dschg_en <= 1'b0;
			en_d     <= 1'b0;
		end else if (i_reg_reset) begin
			// [RULE14] register reset clears enable
			adc_ctrl <= `CHGADC_RST_ADC_CTRL;
			dis0     <= `CHGADC_RST_DIS;
			dis1     <= `CHGADC_RST_DIS;
			dschg_en <= 1'b0;
			en_d     <= 1'b0;
		end else begin
			en_d <= adc_ctrl[`CHGADC_BIT_EN];
			if (i_reg_wr && i_reg_addr == `CHGADC_OFS_ADC_CTRL)
				adc_ctrl <= {i_reg_wdata[7:2], 2'b00};
			if (i_reg_wr && i_reg_addr == `CHGADC_OFS_ADC_DIS0)
				dis0 <= {i_reg_wdata[7:1], 1'b0};
			if (i_reg_wr && i_reg_addr == `CHGADC_OFS_ADC_DIS1)
				dis1 <= {i_reg_wdata[7:4], 4'h0};
			if (i_reg_wr && i_reg_addr == `CHGADC_OFS_CHG_CTRL)
				dschg_en <= i_reg_wdata[`CHGADC_BIT_DSCHG_EN];
			// [RULE15] one-shot pass clears enable at its end
			if (adc_ctrl[`CHGADC_BIT_RATE] && last_chan &&
			    ((state == S_WAIT && i_conv_done) || (state == S_PICK && ch_off[8])))
				adc_ctrl[`CHGADC_BIT_EN] <= 1'b0;
			// [RULE14] watchdog expiry clears enable, wins over writes
			if (i_wdt_expire)
				adc_ctrl[`CHGADC_BIT_EN] <= 1'b0;
		end
	end

	// scan state choice
	always @* begin
		next_state = state;
		case (state)
			S_IDLE: begin
				// [RULE14] conversions only while enabled
				if (adc_ctrl[`CHGADC_BIT_EN])
					next_state = S_PICK;
			end
			S_PICK: begin
				if (!adc_ctrl[`CHGADC_BIT_EN])
					next_state = S_IDLE;
				else if (!ch_off[chan])
					next_state = S_WAIT;
			end
			S_WAIT: begin
				// an accepted request always runs to its result
				if (i_conv_done)
					next_state = S_PICK;
			end
			default: next_state = S_IDLE;
		endcase
	end

	// scan registers and converter request
	always @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			state        <= S_IDLE;
			chan         <= `CHGADC_CH_IBUS;
			o_conv_start <= 1'b0;
			o_conv_chan  <= `CHGADC_CH_IBUS;
		end else begin
			state        <= next_state;
			o_conv_start <= 1'b0;
			if (state == S_IDLE)
				chan <= `CHGADC_CH_IBUS;
			// [RULE15] continuous mode wraps to first channel
			if ((state == S_PICK && ch_off[chan]) || (state == S_WAIT && i_conv_done))
				chan <= last_chan ? `CHGADC_CH_IBUS : chan + 4'h1;
			if (state == S_PICK && adc_ctrl[`CHGADC_BIT_EN] && !ch_off[chan]) begin
				o_conv_start <= 1'b1;
				o_conv_chan  <= chan;
			end
		end
	end

	// one cell per channel; current and die temperature are signed
	genvar g;
	generate
		for (g = 0; g < `CHGADC_NCH; g = g + 1) begin : g_cell
			// [RULE1] [RULE3] [RULE11] two's complement cells
			// [RULE13] loaded only on completion of own channel
			chgadc_result_cell #(
				.IS_SIGNED ((g == 0) || (g == 1) || (g == 8))
			) u_cell (
				.i_clk       (i_mclk),
				.i_rst_n     (rst_n),
				.i_load      (state == S_WAIT && i_conv_done && chan == g),
				.i_sample    (sample),
				.i_avg       (adc_ctrl[`CHGADC_BIT_AVG]),
				.i_avg_init  (adc_ctrl[`CHGADC_BIT_AVG_INIT]),
				.i_run_start (run_start),
				.o_value     (values[g*16 +: 16])
			);
		end
	endgenerate

	// read port, one cycle latency
	always @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
			shadow       <= 8'h00;
			shadow_chan  <= 4'h0;
			shadow_ok    <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				shadow_ok <= 1'b0;
				// [RULE2] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9] [RULE10] codes pass unchanged
				if (res_hit && !rel[0]) begin
					// [RULE12] msb read freezes the lsb
					o_reg_rdata <= res_word[15:8];
					shadow      <= res_word[7:0];
					shadow_chan <= res_idx;
					shadow_ok   <= 1'b1;
				end else if (res_hit)
					o_reg_rdata <= (shadow_ok && shadow_chan == res_idx) ? shadow : res_word[7:0];
				else if (i_reg_addr == `CHGADC_OFS_ADC_CTRL)
					o_reg_rdata <= adc_ctrl;
				else if (i_reg_addr == `CHGADC_OFS_ADC_DIS0)
					o_reg_rdata <= dis0;
				else if (i_reg_addr == `CHGADC_OFS_ADC_DIS1)
					o_reg_rdata <= dis1;
				else if (i_reg_addr == `CHGADC_OFS_CHG_CTRL)
					o_reg_rdata <= {2'b00, dschg_en, 5'h00};
				else
					o_reg_rdata <= 8'h00;    // unmapped reads zero
			end
		end
	end
endmodule // chgadc_results

/* chgadc_conv_model.sv */
// Purpose: converter stand-in answering each start request
// Assumes: start is a one-cycle pulse from the result bank
// Notes:   idle data line shows the inverse of the last code
module chgadc_conv_model (
	input  wire logic        i_clk,
	input  wire logic        i_start,
	input  wire logic [15:0] i_val,
	input  wire logic        i_slow,
	output logic             o_done = 1'b0,
	output logic [15:0]      o_data = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ps;
	int          wait_cnt = 0;      // cycles left before done
	logic [15:0] last     = 16'h0000; // last code handed over
	// answer after one or five cycles, never stale data when idle
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		o_data <= ~last;
		if (i_start) begin
			wait_cnt <= i_slow ? 5 : 1;
		end else if (wait_cnt == 1) begin
			o_done   <= 1'b1;
			o_data   <= i_val;
			last     <= i_val;
			wait_cnt <= 0;
		end else if (wait_cnt > 1) begin
			wait_cnt <= wait_cnt - 1;
		end
	end
endmodule // chgadc_conv_model

/* chgadc_results_monitor.sv */
// Purpose: port checks on the result bank
// Assumes: one clock, async active-low reset
// Notes:   bound to every result bank instance
module chgadc_results_monitor (
	input wire logic       i_mclk,
	input wire logic       i_nrst,
	input wire logic       i_wdt_expire,
	input wire logic       i_reg_rd,
	input wire logic       o_reg_rvalid,
	input wire logic       o_conv_start,
	input wire logic [3:0] o_conv_chan,
	input wire logic       i_conv_done,
	input wire logic       o_conv_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
	a_answer_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("answer without read");
	a_start_pulse: assert property (o_conv_start |=> !o_conv_start) else $error("start too long");
	a_start_busy: assert property (o_conv_start |-> o_conv_busy) else $error("start without busy");
	a_chan_range: assert property (o_conv_start |-> o_conv_chan <= 4'h8) else $error("bad channel");
	a_chan_hold: assert property (!o_conv_start |=> o_conv_start || $stable(o_conv_chan)) else $error("chan moved");
	a_busy_done: assert property (o_conv_busy && i_conv_done |=> !o_conv_busy) else $error("busy after done");
	a_wdt_stop: assert property (i_wdt_expire |-> ##2 !o_conv_start [*6]) else $error("start after watchdog");
endmodule // chgadc_results_monitor

bind chgadc_results chgadc_results_monitor u_mon (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_wdt_expire(i_wdt_expire),
	.i_reg_rd(i_reg_rd), .o_reg_rvalid(o_reg_rvalid), .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan),
	.i_conv_done(i_conv_done), .o_conv_busy(o_conv_busy));

/* tb_top.sv */
// Purpose: self-checking bench for the result bank
// Assumes: msb byte at the result offset, lsb at the next one
// Notes:   codes kept even so averages stay exact
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_mclk = 0, i_nrst = 0, i_reg_reset = 0, i_wdt_expire = 0, i_reg_wr = 0, i_reg_rd = 0;
	logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
	logic        o_reg_rvalid, o_conv_start, i_conv_done, o_conv_busy, slow = 0;
	logic [3:0]  o_conv_chan;
	logic [15:0] i_conv_data, val = 16'h0000, rdat, exp_v [9]; // bench copy of results
	logic [8:0]  off_m = 9'h000; // channels switched off
	bit          dsch = 0;
	int          seed = 14, error_cnt = 0, n_tests = 0, cyc = 0, k;
	chgadc_results u_chgadc_results (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_reset(i_reg_reset),
		.i_wdt_expire(i_wdt_expire), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
		.o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan), .i_conv_done(i_conv_done),
		.i_conv_data(i_conv_data), .o_conv_busy(o_conv_busy));
	chgadc_conv_model u_chgadc_conv_model (.i_clk(i_mclk), .i_start(o_conv_start), .i_val(val),
		.i_slow(slow), .o_done(i_conv_done), .o_data(i_conv_data));
	always #2 i_mclk = ~i_mclk;
	// hang guard, far above a normal run
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	task report_and_stop;
		if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk) {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
		@(posedge i_mclk) i_reg_wr <= 1'b0;
	endtask
	// back-to-back byte reads so the low byte is the frozen one
	task rd16(input logic [7:0] a);
		@(posedge i_mclk) {i_reg_addr, i_reg_rd} <= {a, 1'b1};
		@(posedge i_mclk) i_reg_addr <= a + 8'h01;
		#1 rdat[15:8] = o_reg_rdata;
		chk("read_valid", 16'h0001, {15'h0000, o_reg_rvalid});
		@(posedge i_mclk) i_reg_rd <= 1'b0;
		#1 rdat[7:0] = o_reg_rdata;
	endtask
	task chkall;
		for (int j = 0; j < 9; j++) begin
			rd16(8'(8'h31 + 2 * j));
			chk("result", exp_v[j], rdat);
		end
	endtask
	function logic [15:0] avg(input logic [15:0] a, input logic [15:0] b, input bit sg);
		logic [16:0] t;
		t = {sg & a[15], a} + {sg & b[15], b};
		return t[16:1];
	endfunction
	// one-shot pass with a negative even code, then bench update
	task run(input logic [7:0] ctrl);
		logic [15:0] s;
		val  <= 16'($random(seed)) & 16'hFFFE | 16'h8000;
		slow <= 1'($random(seed));
		wr(8'h2E, ctrl);
		rdat = 16'hFFFF;
		for (int j = 0; j < 100 && rdat[15]; j++) rd16(8'h2E);
		chk("enable", 16'h0000, rdat & 16'h8000);
		for (int j = 0; j < 9; j++) if (!off_m[j]) begin
			s = (j == 1 && !dsch) ? 16'h0000 : val;
			if (ctrl[3] && !ctrl[2]) s = avg(exp_v[j], s, j == 0 || j == 1 || j == 8);
			exp_v[j] = s;
		end
	endtask
	initial begin
		for (k = 0; k < 9; k++) exp_v[k] = 16'h0000;
		repeat (12) @(posedge i_mclk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_mclk);
		for (k = 8'h31; k < 8'h43; k++) wr(8'(k), 8'hFF);
		chkall;
		rd16(8'h43);
		chk("unmapped", 16'h0000, rdat);
		run(8'hC0);
		chkall;
		dsch = 1;
		off_m = 9'b000010001;
		wr(8'h14, 8'h20);
		wr(8'h2F, 8'h80);
		wr(8'h30, 8'h20);
		rd16(8'h2F);
		chk("disable", 16'h8020, rdat);
		run(8'hC0);
		chkall;
		off_m = 9'h000;
		wr(8'h2F, 8'h00);
		wr(8'h30, 8'h00);
		run(8'hC8);
		chkall;
		run(8'hCC);
		chkall;
		// free-running pass with a positive code
		val <= 16'($random(seed)) & 16'h7FFE;
		wr(8'h2E, 8'h80);
		repeat (300) @(posedge i_mclk);
		rd16(8'h2E);
		chk("control", 16'h8000, rdat);
		for (k = 0; k < 9; k++) exp_v[k] = val;
		chkall;
		@(posedge i_mclk) i_wdt_expire <= 1'b1;
		@(posedge i_mclk) i_wdt_expire <= 1'b0;
		rd16(8'h2E);
		chk("control", 16'h0000, rdat);
		rd16(8'h13);
		chk("sense_enable", 16'h0020, rdat);
		@(posedge i_mclk) i_reg_reset <= 1'b1;
		@(posedge i_mclk) i_reg_reset <= 1'b0;
		rd16(8'h2E);
		chk("control", 16'h3000, rdat);
		rd16(8'h13);
		chk("sense_enable", 16'h0000, rdat);
		chkall;
		report_and_stop;
	end
endmodule // tb_top
